// ==== include/ccc_chk_if.sv ====
`timescale 1ns/10ps
interface ccc_chk_if;
    import ccc_pkg::*;
    logic               req;
    logic [RATE_W-1:0]  rate;
    logic [CLASS_W-1:0] cls;
    logic               done;
    logic               ok;
    modport fsm (output req, output rate, output cls, input done, input ok);
    modport chk (input req, input rate, input cls, output done, output ok);
endinterface : ccc_chk_if

// ==== include/ccc_pkg.sv ====
package ccc_pkg;
    // message codes on the signalling channel
    localparam int          MSG_W          = 4;
    localparam logic [3:0]  MSG_NONE       = 4'h0;
    localparam logic [3:0]  MSG_SETUP      = 4'h1;
    localparam logic [3:0]  MSG_SETUP_ACK  = 4'h2;
    localparam logic [3:0]  MSG_CALL_PROC  = 4'h3;
    localparam logic [3:0]  MSG_ALERTING   = 4'h4;
    localparam logic [3:0]  MSG_CONNECT    = 4'h5;
    localparam logic [3:0]  MSG_CONN_ACK   = 4'h6;
    localparam logic [3:0]  MSG_DISCONNECT = 4'h7;
    localparam logic [3:0]  MSG_RELEASE    = 4'h8;
    localparam logic [3:0]  MSG_REL_CMPL   = 4'h9;
    // cause values
    localparam logic [6:0]  CAUSE_NONE     = 7'h00;
    localparam logic [6:0]  CAUSE_BUSY     = 7'h11;  // 17
    localparam logic [6:0]  CAUSE_REJECTED = 7'h15;  // 21
    localparam logic [6:0]  CAUSE_OUT_ORD  = 7'h1B;  // 27
    localparam logic [6:0]  CAUSE_INCOMPAT = 7'h58;  // 88
    // terminal readiness codes
    localparam logic [1:0]  TS_READY       = 2'h0;
    localparam logic [1:0]  TS_CTRL_NR     = 2'h1;
    localparam logic [1:0]  TS_UNCTRL_NR   = 2'h2;
    localparam logic [1:0]  TS_BUSY        = 2'h3;
    // condition on the r lead towards the terminal
    localparam logic [1:0]  RC_ZERO        = 2'h0;
    localparam logic [1:0]  RC_ONE         = 2'h1;
    localparam logic [1:0]  RC_BEL         = 2'h2;
    localparam logic [1:0]  RC_SYN         = 2'h3;
    // offered call descriptors
    localparam int          RATE_W         = 4;
    localparam int          CLASS_W        = 5;
    localparam logic [4:0]  CLASS_19       = 5'h13;
    localparam logic [3:0]  RATE_DEFAULT   = 4'h3;
    localparam logic [4:0]  CLASS_DEFAULT  = 5'h03;
endpackage : ccc_pkg

// ==== logic/ccc_call_ctrl.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module ccc_call_ctrl
    import ccc_pkg::*;
#(
    parameter logic [RATE_W-1:0]  OWN_RATE  = RATE_DEFAULT,
    parameter logic [CLASS_W-1:0] OWN_CLASS = CLASS_DEFAULT
) (
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic               i_ce,
    input  wire logic               i_msg_valid,
    input  wire logic [MSG_W-1:0]   i_msg_type,
    input  wire logic [RATE_W-1:0]  i_offer_rate,
    input  wire logic [CLASS_W-1:0] i_offer_class,
    input  wire logic [1:0]         i_term_status,
    input  wire logic               i_manual_answer,
    input  wire logic               i_incompat_reply,
    input  wire logic               i_frame_aligned,
    input  wire logic               i_dte_t,
    input  wire logic               i_dte_c,
    output logic                    o_msg_valid,
    output logic [MSG_W-1:0]        o_msg_type,
    output logic [6:0]              o_msg_cause,
    output logic [1:0]              o_dce_r,
    output logic                    o_dce_i,
    output logic                    o_bch_conn,
    output logic                    o_bch_stat_valid,
    output logic                    o_bch_stat_b,
    output logic                    o_bch_stat_s,
    output logic                    o_switch_thru,
    output logic                    o_callref_held
);
    localparam logic IS_C19 = (OWN_CLASS == CLASS_19);

    typedef enum logic [2:0] {
        S_READY, S_CHECK, S_OFFERED, S_WAIT_ACK, S_OUT_WAIT, S_ALIGN, S_DATA, S_CLEAR
    } ccc_state_t;

    ccc_chk_if chk_if ();

    ccc_state_t       state_r,  state_nxt;
    logic [1:0]       ts_r,     ts_nxt;
    logic [1:0]       t_sync_r, t_sync_nxt;
    logic [1:0]       c_sync_r, c_sync_nxt;
    logic             mv_r,     mv_nxt;
    logic [MSG_W-1:0] mt_r,     mt_nxt;
    logic [6:0]       mc_r,     mc_nxt;
    logic [1:0]       r_r,      r_nxt;
    logic             i_r,      i_nxt;
    logic             bc_r,     bc_nxt;
    logic             sv_r,     sv_nxt;
    logic             sb_r,     sb_nxt;
    logic             ss_r,     ss_nxt;
    logic             sw_r,     sw_nxt;
    logic             cr_r,     cr_nxt;
    logic             dte_t;
    logic             dte_c;
    logic             rx;

    ccc_compat #(
        .OWN_RATE  (OWN_RATE),
        .OWN_CLASS (OWN_CLASS)
    ) u_compat (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .chk       (chk_if.chk)
    );

    // setup descriptors go to the checker
    assign chk_if.req  = i_msg_valid && (i_msg_type == MSG_SETUP) && (state_r == S_READY);
    assign chk_if.rate = i_offer_rate;
    assign chk_if.cls  = i_offer_class;

    assign dte_t = t_sync_r[1];
    assign dte_c = c_sync_r[1];
    assign rx    = i_msg_valid;

    ////////////////////////////////////////////////////////////////////////////
    // call control next state
    always_comb begin
        state_nxt  = state_r;
        ts_nxt     = i_term_status;
        t_sync_nxt = {t_sync_r[0], i_dte_t};
        c_sync_nxt = {c_sync_r[0], i_dte_c};
        mv_nxt     = 1'b0;
        mt_nxt     = mt_r;
        mc_nxt     = CAUSE_NONE;
        r_nxt      = r_r;
        i_nxt      = i_r;
        bc_nxt     = bc_r;
        sv_nxt     = 1'b0;
        sb_nxt     = sb_r;
        ss_nxt     = ss_r;
        sw_nxt     = sw_r;
        cr_nxt     = cr_r;
        case (state_r)
            S_READY: begin
                if (rx && i_msg_type == MSG_SETUP) begin
                    state_nxt = S_CHECK;
                end else if (rx && (i_msg_type == MSG_CALL_PROC ||
                                    i_msg_type == MSG_SETUP_ACK)) begin
                    bc_nxt    = 1'b1;
                    cr_nxt    = 1'b1;
                    sv_nxt    = !IS_C19;
                    sb_nxt    = 1'b1;
                    ss_nxt    = 1'b0;
                    r_nxt     = RC_SYN;
                    state_nxt = S_OUT_WAIT;
                end
            end
            S_CHECK: begin
                state_nxt = S_READY;
                if (chk_if.done && !chk_if.ok) begin
                    if (i_incompat_reply) begin
                        mv_nxt = 1'b1;
                        mt_nxt = MSG_REL_CMPL;
                        mc_nxt = CAUSE_INCOMPAT;
                    end
                end else if (chk_if.done && ts_r != TS_READY) begin
                    mv_nxt = 1'b1;
                    mt_nxt = MSG_REL_CMPL;
                    case (ts_r)
                        TS_CTRL_NR:   mc_nxt = CAUSE_REJECTED;
                        TS_UNCTRL_NR: mc_nxt = CAUSE_OUT_ORD;
                        default:      mc_nxt = CAUSE_BUSY;
                    endcase
                end else if (chk_if.done) begin
                    cr_nxt    = 1'b1;
                    r_nxt     = RC_BEL;                // incoming call
                    mv_nxt    = i_manual_answer;
                    mt_nxt    = MSG_ALERTING;
                    state_nxt = S_OFFERED;
                end
            end
            S_OFFERED: begin
                // automatic answer connects at once, manual waits for accept
                if (!i_manual_answer || (dte_t && dte_c)) begin
                    mv_nxt    = 1'b1;
                    mt_nxt    = MSG_CONNECT;
                    state_nxt = S_WAIT_ACK;
                end
            end
            S_WAIT_ACK: begin
                if (rx && i_msg_type == MSG_CONN_ACK) begin
                    bc_nxt    = 1'b1;
                    sv_nxt    = !IS_C19;
                    sb_nxt    = 1'b1;
                    ss_nxt    = 1'b0;
                    r_nxt     = RC_ONE;
                    i_nxt     = 1'b0;
                    state_nxt = S_ALIGN;
                end
            end
            S_OUT_WAIT: begin
                if (rx && i_msg_type == MSG_ALERTING) begin
                    r_nxt = RC_SYN;
                end else if (rx && i_msg_type == MSG_CONNECT) begin
                    bc_nxt    = 1'b1;
                    r_nxt     = RC_ONE;
                    i_nxt     = 1'b0;
                    state_nxt = S_ALIGN;
                end
            end
            S_ALIGN: begin
                if (i_frame_aligned) begin
                    sw_nxt    = 1'b1;
                    i_nxt     = 1'b1;
                    state_nxt = S_DATA;
                end
            end
            S_DATA: begin
                if (!dte_t && !dte_c) begin
                    sw_nxt    = 1'b0;
                    sv_nxt    = !IS_C19;
                    sb_nxt    = 1'b0;
                    ss_nxt    = 1'b0;
                    r_nxt     = RC_ZERO;
                    i_nxt     = 1'b0;
                    mv_nxt    = 1'b1;
                    mt_nxt    = MSG_DISCONNECT;
                    bc_nxt    = 1'b0;
                    state_nxt = S_CLEAR;
                end
            end
            S_CLEAR: begin
                // release ends the clearing: confirm, free bearer and reference, dce ready
                if (rx && i_msg_type == MSG_RELEASE) begin
                    mv_nxt    = 1'b1;
                    mt_nxt    = MSG_REL_CMPL;
                    r_nxt     = RC_ONE;
                    i_nxt     = 1'b0;
                    bc_nxt    = 1'b0;
                    cr_nxt    = 1'b0;
                    state_nxt = S_READY;
                end
            end
            default: state_nxt = S_READY;
        endcase
        // clearing by the network overrides any busy state other than S_CHECK and S_CLEAR
        if (state_r != S_READY && state_r != S_CHECK && state_r != S_CLEAR && rx) begin
            if (i_msg_type == MSG_DISCONNECT) begin
                mv_nxt    = 1'b1;
                mt_nxt    = MSG_RELEASE;
                mc_nxt    = CAUSE_NONE;
                r_nxt     = RC_ZERO;
                i_nxt     = 1'b0;
                sw_nxt    = 1'b0;
                state_nxt = S_CLEAR;
            end else if (i_msg_type == MSG_RELEASE) begin
                mv_nxt    = 1'b1;
                mt_nxt    = MSG_REL_CMPL;
                mc_nxt    = CAUSE_NONE;
                r_nxt     = RC_ONE;
                i_nxt     = 1'b0;
                sw_nxt    = 1'b0;
                bc_nxt    = 1'b0;
                cr_nxt    = 1'b0;
                state_nxt = S_READY;
            end
        end
        // release complete returns both sides to ready
        if (state_r != S_READY && state_r != S_CHECK && rx && i_msg_type == MSG_REL_CMPL) begin
            r_nxt     = RC_ONE;
            i_nxt     = 1'b0;
            sw_nxt    = 1'b0;
            bc_nxt    = 1'b0;
            cr_nxt    = 1'b0;
            state_nxt = S_READY;
        end
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r  <= S_READY;
            ts_r     <= TS_READY;
            t_sync_r <= 2'h0;
            c_sync_r <= 2'h0;
            mv_r     <= 1'b0;
            mt_r     <= MSG_NONE;
            mc_r     <= CAUSE_NONE;
            r_r      <= RC_ONE;
            i_r      <= 1'b0;
            bc_r     <= 1'b0;
            sv_r     <= 1'b0;
            sb_r     <= 1'b0;
            ss_r     <= 1'b0;
            sw_r     <= 1'b0;
            cr_r     <= 1'b0;
        end else if (i_ce) begin
            state_r  <= state_nxt;
            ts_r     <= ts_nxt;
            t_sync_r <= t_sync_nxt;
            c_sync_r <= c_sync_nxt;
            mv_r     <= mv_nxt;
            mt_r     <= mt_nxt;
            mc_r     <= mc_nxt;
            r_r      <= r_nxt;
            i_r      <= i_nxt;
            bc_r     <= bc_nxt;
            sv_r     <= sv_nxt;
            sb_r     <= sb_nxt;
            ss_r     <= ss_nxt;
            sw_r     <= sw_nxt;
            cr_r     <= cr_nxt;
        end
    end

    // outputs straight from flip-flops
    assign o_msg_valid      = mv_r;
    assign o_msg_type       = mt_r;
    assign o_msg_cause      = mc_r;
    assign o_dce_r          = r_r;
    assign o_dce_i          = i_r;
    assign o_bch_conn       = bc_r;
    assign o_bch_stat_valid = sv_r;
    assign o_bch_stat_b     = sb_r;
    assign o_bch_stat_s     = ss_r;
    assign o_switch_thru    = sw_r;
    assign o_callref_held   = cr_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    relc_ready_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && rx && i_msg_type == MSG_REL_CMPL && state_r != S_READY && state_r != S_CHECK)
        |=> (o_dce_r == RC_ONE) && !o_dce_i && !o_bch_conn && !o_callref_held)
        else $error("release complete did not restore ready");
    notready_cause_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && state_r == S_CHECK && chk_if.ok && ts_r == TS_UNCTRL_NR)
        |=> o_msg_valid && o_msg_type == MSG_REL_CMPL && o_msg_cause == CAUSE_OUT_ORD)
        else $error("not ready cause wrong");
    incompat_quiet_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && state_r == S_CHECK && !chk_if.ok && !i_incompat_reply) |=> !o_msg_valid)
        else $error("incompatible offer answered");
    setup_check_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && state_r == S_READY && rx && i_msg_type == MSG_SETUP)
        |=> state_r == S_CHECK && chk_if.done)
        else $error("setup not checked");
    alert_manual_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_msg_valid && o_msg_type == MSG_ALERTING) |-> $past(i_manual_answer))
        else $error("alerting without manual answer");
    align_first_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_dce_i) |-> o_switch_thru && o_dce_r == RC_ONE && $past(state_r == S_ALIGN))
        else $error("ready for data without alignment");
    class19_quiet_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_bch_stat_valid |-> !IS_C19)
        else $error("in-slot status sent for class 19");
    proc_bearer_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && state_r == S_READY && rx && i_msg_type == MSG_CALL_PROC)
        |=> o_bch_conn && o_bch_stat_b && !o_bch_stat_s && state_r == S_OUT_WAIT)
        else $error("bearer not joined on call proceeding");
    status_track_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce |=> ts_r == $past(i_term_status))
        else $error("readiness status not tracked");
endmodule : ccc_call_ctrl

// ==== logic/ccc_compat.sv ====
`timescale 1ns/10ps
module ccc_compat
    import ccc_pkg::*;
#(
    parameter logic [RATE_W-1:0]  OWN_RATE  = RATE_DEFAULT,
    parameter logic [CLASS_W-1:0] OWN_CLASS = CLASS_DEFAULT
) (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_ce,
    ccc_chk_if.chk    chk
);
    logic done_r;
    logic done_nxt;
    logic ok_r;
    logic ok_nxt;

    // rate and class must both match the attached terminal
    always_comb begin
        done_nxt = chk.req;
        ok_nxt   = ok_r;
        if (chk.req) begin
            ok_nxt = (chk.rate == OWN_RATE) && (chk.cls == OWN_CLASS);
        end
    end

    // result register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_r <= 1'b0;
            ok_r   <= 1'b0;
        end else if (i_ce) begin
            done_r <= done_nxt;
            ok_r   <= ok_nxt;
        end
    end

    assign chk.done = done_r;
    assign chk.ok   = ok_r;

    // a request with the clock enable high yields a result on the next edge
    chk_latency_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (chk.req && i_ce) |=> done_r)
        else $error("compatibility result missing");
endmodule : ccc_compat

// ==== verification/ccc_net_model.sv ====
`timescale 1ns/10ps
module ccc_net_model
    import ccc_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_cmd_valid,
    input  wire logic [MSG_W-1:0] i_cmd_type,
    input  wire logic [3:0]       i_gap,
    input  wire logic             i_dut_valid,
    input  wire logic [MSG_W-1:0] i_dut_type,
    output logic                  o_msg_valid,
    output logic [MSG_W-1:0]      o_msg_type
);
    logic             pend_r;
    logic [MSG_W-1:0] reply_r;
    logic [3:0]       wait_r;

    //////////////////////////////////////////////////////////////////////////////////////
    // network side: injected messages, then replies after i_gap idle cycles
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_r      <= 1'b0;
            reply_r     <= MSG_NONE;
            wait_r      <= 4'h0;
            o_msg_valid <= 1'b0;
            o_msg_type  <= MSG_NONE;
        end else begin
            o_msg_valid <= 1'b0;
            o_msg_type  <= ~o_msg_type;  // idle code toggles between the last message code and its complement
            if (i_cmd_valid) begin
                o_msg_valid <= 1'b1;
                o_msg_type  <= i_cmd_type;
            end else if (pend_r && wait_r == 4'h0) begin
                o_msg_valid <= 1'b1;
                o_msg_type  <= reply_r;
                pend_r      <= 1'b0;
            end else if (pend_r) begin
                wait_r <= wait_r - 4'h1;
            end
            if (i_dut_valid) begin
                wait_r <= i_gap;
                pend_r <= (i_dut_type inside {MSG_CONNECT, MSG_DISCONNECT, MSG_RELEASE});
                case (i_dut_type)
                    MSG_CONNECT:    reply_r <= MSG_CONN_ACK;  // this adaptor is chosen
                    MSG_DISCONNECT: reply_r <= MSG_RELEASE;
                    MSG_RELEASE:    reply_r <= MSG_REL_CMPL;
                    default:        reply_r <= MSG_NONE;  // negative answer absorbed
                endcase
            end
        end
    end
endmodule : ccc_net_model

// ==== verification/test_isdn_x21_call_control.sv ====
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module test_isdn_x21_call_control
    import ccc_pkg::*;
;
    typedef struct packed {
        logic [1:0] ts;
        logic       man;
        logic       inc;
        logic [3:0] rate;
        logic [4:0] cls;
        logic       ev;
        logic [3:0] et;
        logic [6:0] ec;
        logic [1:0] er;
    } ccc_row_t;
    // offer cases: readiness, answer mode, descriptors, expected answer at check+1
    ccc_row_t rows [6] = '{
        '{TS_CTRL_NR, 1'b0, 1'b0, RATE_DEFAULT, CLASS_DEFAULT,
          1'b1, MSG_REL_CMPL, CAUSE_REJECTED, RC_ONE},
        '{TS_UNCTRL_NR, 1'b0, 1'b0, RATE_DEFAULT, CLASS_DEFAULT,
          1'b1, MSG_REL_CMPL, CAUSE_OUT_ORD, RC_ONE},
        '{TS_BUSY, 1'b0, 1'b0, RATE_DEFAULT, CLASS_DEFAULT,
          1'b1, MSG_REL_CMPL, CAUSE_BUSY, RC_ONE},
        '{TS_READY, 1'b0, 1'b0, 4'h5, CLASS_DEFAULT, 1'b0, MSG_NONE, CAUSE_NONE, RC_ONE},
        '{TS_READY, 1'b0, 1'b1, RATE_DEFAULT, 5'h04,
          1'b1, MSG_REL_CMPL, CAUSE_INCOMPAT, RC_ONE},
        '{TS_READY, 1'b1, 1'b0, RATE_DEFAULT, CLASS_DEFAULT,
          1'b1, MSG_ALERTING, CAUSE_NONE, RC_BEL}
    };
    logic             clk = 1'b0;
    logic             reset_n;
    logic             cmd_valid;
    logic [MSG_W-1:0] cmd_type;
    logic [3:0]       gap;
    logic             msg_valid;
    logic [MSG_W-1:0] msg_type;
    logic [3:0]       rate;
    logic [4:0]       cls;
    logic [1:0]       ts;
    logic             man, inc, aligned, dte_t, dte_c;
    logic             ov, dce_i, bconn, sv, sb, ss, thru, cref, bconn2, sv2;
    logic [MSG_W-1:0] ot;
    logic [6:0]       oc;
    logic [1:0]       dce_r;
    logic             seen19 = 1'b0;
    int               checked = 0;
    int               mismatches = 0;
    int               cycles = 0;

    //////////////////////////////////////////////////////////////////////////////////////
    // design, class 19 twin and network model
    ccc_call_ctrl i_ccc_call_ctrl (
        .i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1), .i_msg_valid(msg_valid),
        .i_msg_type(msg_type), .i_offer_rate(rate), .i_offer_class(cls),
        .i_term_status(ts), .i_manual_answer(man), .i_incompat_reply(inc),
        .i_frame_aligned(aligned), .i_dte_t(dte_t), .i_dte_c(dte_c),
        .o_msg_valid(ov), .o_msg_type(ot), .o_msg_cause(oc), .o_dce_r(dce_r),
        .o_dce_i(dce_i), .o_bch_conn(bconn), .o_bch_stat_valid(sv), .o_bch_stat_b(sb),
        .o_bch_stat_s(ss), .o_switch_thru(thru), .o_callref_held(cref));
    ccc_call_ctrl #(.OWN_CLASS(CLASS_19)) i_ccc_call_ctrl_c19 (
        .i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1), .i_msg_valid(msg_valid),
        .i_msg_type(msg_type), .i_offer_rate(rate), .i_offer_class(cls),
        .i_term_status(ts), .i_manual_answer(man), .i_incompat_reply(inc),
        .i_frame_aligned(aligned), .i_dte_t(dte_t), .i_dte_c(dte_c),
        .o_msg_valid(), .o_msg_type(), .o_msg_cause(), .o_dce_r(), .o_dce_i(),
        .o_bch_conn(bconn2), .o_bch_stat_valid(sv2), .o_bch_stat_b(), .o_bch_stat_s(),
        .o_switch_thru(), .o_callref_held());
    ccc_net_model i_ccc_net_model (
        .i_clk(clk), .i_reset_n(reset_n), .i_cmd_valid(cmd_valid), .i_cmd_type(cmd_type),
        .i_gap(gap), .i_dut_valid(ov), .i_dut_type(ot), .o_msg_valid(msg_valid),
        .o_msg_type(msg_type));

    // clock, class 19 status watch and hang limit
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (sv2 === 1'b1) seen19 <= 1'b1;
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic net_send(input logic [MSG_W-1:0] m);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_type  <= m;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : net_send

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_msg(input logic [MSG_W-1:0] m, input int lim);
        for (int k = 0; k < lim; k++) begin
            settle(1);
            if (ov === 1'b1 && ot === m) return;
        end
        `CHK("awaited message", {1'b1, m}, {ov, ot})
    endtask : wait_msg

    //////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_type = MSG_NONE;
        gap = 4'h0;
        rate = RATE_DEFAULT;
        cls = CLASS_DEFAULT;
        ts = TS_READY;
        {man, inc, aligned, dte_c} = 4'h0;
        dte_t = 1'b1;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
        `CHK("reset r", RC_ONE, dce_r)
        `CHK("reset bearer", 1'b0, bconn)
        // offer table, each row cleared back to ready
        foreach (rows[k]) begin
            @(posedge clk);
            {ts, man, inc} <= {rows[k].ts, rows[k].man, rows[k].inc};
            {rate, cls}    <= {rows[k].rate, rows[k].cls};
            net_send(MSG_SETUP);
            settle(2);
            `CHK("answer pulse", rows[k].ev, ov)
            `CHK("answer r", rows[k].er, dce_r)
            if (rows[k].ev) begin
                `CHK("answer type", rows[k].et, ot)
                `CHK("answer cause", rows[k].ec, oc)
            end
            net_send(MSG_REL_CMPL);
            settle(3);
        end
        // automatic answer, alignment, terminal clearing with a slow network
        @(posedge clk);
        {ts, man, inc, rate, cls, dte_c} <= {TS_READY, 2'h0, RATE_DEFAULT, CLASS_DEFAULT, 1'b1};
        net_send(MSG_SETUP);
        settle(2);
        `CHK("incoming r", RC_BEL, dce_r)
        `CHK("call ref", 1'b1, cref)
        settle(1);
        `CHK("auto connect", {1'b1, MSG_CONNECT}, {ov, ot})
        for (int k = 0; k < 20 && sv !== 1'b1; k++) settle(1);
        `CHK("status after ack", 2'h2, {sb, ss})
        `CHK("in progress", {RC_ONE, 1'b0}, {dce_r, dce_i})
        settle(3);
        `CHK("no early switch", 2'h0, {thru, dce_i})
        @(posedge clk);
        aligned <= 1'b1;
        @(posedge clk);
        aligned <= 1'b0;
        settle(1);
        `CHK("ready for data", 2'h3, {thru, dce_i})
        @(posedge clk);
        {gap, dte_t, dte_c} <= {4'h6, 2'h0};
        wait_msg(MSG_DISCONNECT, 20);
        `CHK("clear confirm", {RC_ZERO, 1'b0}, {dce_r, bconn})
        wait_msg(MSG_REL_CMPL, 40);
        `CHK("cleared ready", {RC_ONE, 2'h0}, {dce_r, cref, bconn})
        // outgoing call joins bearer, then release complete frees it
        @(posedge clk);
        {gap, dte_t, dte_c} <= {4'h0, 2'h2};
        net_send(MSG_CALL_PROC);
        settle(1);
        `CHK("bearer joined", 3'h7, {bconn, sv, sb})
        `CHK("status on bit", 1'b0, ss)
        `CHK("waiting r", RC_SYN, dce_r)
        `CHK("class 19 joined", 1'b1, bconn2)
        net_send(MSG_REL_CMPL);
        settle(2);
        `CHK("released r", {RC_ONE, 1'b0}, {dce_r, dce_i})
        `CHK("freed", 2'h0, {bconn, cref})
        `CHK("class 19 silent", 1'b0, seen19)
        // outgoing via setup ack, then network clearing back to ready
        net_send(MSG_SETUP_ACK);
        settle(1);
        `CHK("ack joined", {1'b1, RC_SYN}, {bconn, dce_r})
        net_send(MSG_CONNECT);
        settle(1);
        `CHK("connect r", {RC_ONE, 1'b0}, {dce_r, dce_i})
        net_send(MSG_DISCONNECT);
        settle(1);
        `CHK("net clear", {1'b1, MSG_RELEASE, RC_ZERO}, {ov, ot, dce_r})
        settle(3);
        `CHK("net cleared", {RC_ONE, 3'h0}, {dce_r, dce_i, bconn, cref})
        tally_and_finish();
    end
endmodule : test_isdn_x21_call_control
